// ===== core/overcurrent_source_select.sv
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// How it works
// - each of ports 1 to 6 has an 8-bit register whose low four bits pick the sense source.
// - code 0000b marks the port disabled and it gives no indication.
// - code 0001b takes the indication from the port's dedicated sense pin.
// - code 0010b takes the indication from the port's general-purpose pin.
// - code 1111b forces the indication on for test.
// - the upper four bits are reserved, readable and writable, with no effect.
module overcurrent_source_select
  import ocsel_pkg::*;
(
  input wire logic MCLK_I, // 25 MHz clock
  input wire logic RESET_I, // synchronous reset, high
  input wire logic [15:0] AVS_ADDRESS_I, // byte address
  input wire logic AVS_READ_I, // read request
  input wire logic AVS_WRITE_I, // write request
  input wire logic [31:0] AVS_WRITEDATA_I, // write data
  input wire logic [3:0] AVS_BYTEENABLE_I, // byte enables
  output logic [31:0] AVS_READDATA_O, // read data
  output logic AVS_WAITREQUEST_O, // stall
  input wire logic [5:0] OVERCURRENT_SENSE_PIN_I, // dedicated sense pins
  input wire logic [5:0] OVERCURRENT_SENSE_GPIO_I, // general-purpose sense pins
  output logic [5:0] OVERCURRENT_SENSE_O, // per-port indication
  output logic IRQ_O // level interrupt
);
  ocsel_cfg_if cfg ();

  logic [7:0] source [6];
  logic [5:0] ind_q;
  logic [5:0] ev_status;
  logic [5:0] ev_enable;
  logic [5:0] ev_rise;
  logic [5:0] clr_mask;
  logic busy;
  logic req;
  logic [31:0] next_rdata;

  function automatic int port_index(input logic [15:0] a);
    int r;
    r = -1;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (a == PORT1_OVERCURRENT_SOURCE_ADDR + 16'(i) * SOURCE_STRIDE) begin
        r = i;
      end
    end
    return r;
  endfunction

  // ==========================================
  // submodules
  ocsel_sync u_sync (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .pin_i(OVERCURRENT_SENSE_PIN_I),
    .gpio_i(OVERCURRENT_SENSE_GPIO_I),
    .cfg(cfg.sync)
  );

  ocsel_route u_route (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .cfg(cfg.route)
  );

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_src
    assign cfg.source[g] = source[g];
  end

  // ==========================================
  // bus handshake: one wait cycle, answer on the second edge
  assign req = AVS_READ_I | AVS_WRITE_I;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      busy <= 1'b0;
    end else begin
      busy <= req & ~busy;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      AVS_WAITREQUEST_O <= ~(req & ~busy);
    end
  end

  // ==========================================
  // source registers, all eight bits stored
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        source[i] <= SOURCE_RESET;
      end
    end else if (AVS_WRITE_I && busy && AVS_BYTEENABLE_I[0]) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        if (port_index(AVS_ADDRESS_I) == i) begin
          source[i] <= AVS_WRITEDATA_I[7:0];
        end
      end
    end
  end

  // ==========================================
  // events: rising indication sets sticky status
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ind_q <= 6'h00;
    end else begin
      ind_q <= cfg.indication;
    end
  end

  assign ev_rise = cfg.indication & ~ind_q;
  assign clr_mask = (AVS_WRITE_I && busy && AVS_ADDRESS_I == EVENT_CLEAR_ADDR
                     && AVS_BYTEENABLE_I[0]) ? AVS_WRITEDATA_I[5:0] : 6'h00;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ev_status <= EVENT_RESET;
    end else begin
      // set wins over clear
      ev_status <= (ev_status & ~clr_mask) | ev_rise;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ev_enable <= EVENT_RESET;
    end else if (AVS_WRITE_I && busy && AVS_ADDRESS_I == EVENT_ENABLE_ADDR
                 && AVS_BYTEENABLE_I[0]) begin
      ev_enable <= AVS_WRITEDATA_I[5:0];
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(((ev_status & ~clr_mask) | ev_rise) & ev_enable);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      OVERCURRENT_SENSE_O <= 6'h00;
    end else begin
      OVERCURRENT_SENSE_O <= cfg.indication;
    end
  end

  // ==========================================
  // read mux
  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (port_index(AVS_ADDRESS_I) >= 0) begin
      next_rdata = {24'h00_0000, source[port_index(AVS_ADDRESS_I)]};
    end else if (AVS_ADDRESS_I == EVENT_STATUS_ADDR) begin
      next_rdata = {26'h000_0000, ev_status};
    end else if (AVS_ADDRESS_I == EVENT_ENABLE_ADDR) begin
      next_rdata = {26'h000_0000, ev_enable};
    end else if (AVS_ADDRESS_I == INDICATION_ADDR) begin
      next_rdata = {26'h000_0000, cfg.indication};
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      AVS_READDATA_O <= UNMAPPED_READ;
    end else if (AVS_READ_I && !busy) begin
      AVS_READDATA_O <= next_rdata;
    end
  end

  // ==========================================
  // checks
  property p_wait_one;
    @(posedge MCLK_I) disable iff (RESET_I)
    ($rose(req) && !busy) |=> !AVS_WAITREQUEST_O;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer after one wait cycle");

  property p_write_store;
    @(posedge MCLK_I) disable iff (RESET_I)
    (AVS_WRITE_I && busy && AVS_BYTEENABLE_I[0]
     && AVS_ADDRESS_I == PORT1_OVERCURRENT_SOURCE_ADDR)
    |=> (source[0] == $past(AVS_WRITEDATA_I[7:0]));
  endproperty
  a_write_store: assert property (p_write_store) else $error("source write lost");

  property p_out_follows;
    @(posedge MCLK_I) disable iff (RESET_I)
    (source[0][3:0] == SRC_FORCE)[*3] |-> OVERCURRENT_SENSE_O[0];
  endproperty
  a_out_follows: assert property (p_out_follows) else $error("forced output missing");

  property p_irq;
    @(posedge MCLK_I) disable iff (RESET_I)
    (|(ev_status & ev_enable)) && clr_mask == 6'h00 |=> IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_port2_upper;
    @(posedge MCLK_I) disable iff (RESET_I)
    (AVS_WRITE_I && busy && AVS_BYTEENABLE_I[0]
     && AVS_ADDRESS_I == PORT2_OVERCURRENT_SOURCE_ADDR)
    |=> (source[1][7:4] == $past(AVS_WRITEDATA_I[7:4]));
  endproperty
  a_port2_upper: assert property (p_port2_upper) else $error("upper bits not kept");

  property p_port6_store;
    @(posedge MCLK_I) disable iff (RESET_I)
    (AVS_WRITE_I && busy && AVS_BYTEENABLE_I[0]
     && AVS_ADDRESS_I == PORT6_OVERCURRENT_SOURCE_ADDR)
    |=> (source[5] == $past(AVS_WRITEDATA_I[7:0]));
  endproperty
  a_port6_store: assert property (p_port6_store) else $error("port 6 write lost");

  property p_lane_ignored;
    @(posedge MCLK_I) disable iff (RESET_I)
    (AVS_WRITE_I && busy && !AVS_BYTEENABLE_I[0]) |=> (source[0] == $past(source[0]));
  endproperty
  a_lane_ignored: assert property (p_lane_ignored) else $error("masked write stored");

  property p_enable_store;
    @(posedge MCLK_I) disable iff (RESET_I)
    (AVS_WRITE_I && busy && AVS_BYTEENABLE_I[0]
     && AVS_ADDRESS_I == EVENT_ENABLE_ADDR)
    |=> (ev_enable == $past(AVS_WRITEDATA_I[5:0]));
  endproperty
  a_enable_store: assert property (p_enable_store) else $error("enable write lost");

  property p_wait_single;
    @(posedge MCLK_I) disable iff (RESET_I)
    !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O;
  endproperty
  a_wait_single: assert property (p_wait_single) else $error("waitrequest low too long");

  property p_wait_idle;
    @(posedge MCLK_I) disable iff (RESET_I)
    !req |=> AVS_WAITREQUEST_O;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");

  property p_busy_one;
    @(posedge MCLK_I) disable iff (RESET_I)
    busy |=> !busy;
  endproperty
  a_busy_one: assert property (p_busy_one) else $error("busy longer than one cycle");

  property p_read_source;
    @(posedge MCLK_I) disable iff (RESET_I)
    (AVS_READ_I && !busy && AVS_ADDRESS_I == PORT3_OVERCURRENT_SOURCE_ADDR)
    |=> (AVS_READDATA_O == {24'h00_0000, $past(source[2])});
  endproperty
  a_read_source: assert property (p_read_source) else $error("source readback wrong");

  property p_read_status;
    @(posedge MCLK_I) disable iff (RESET_I)
    (AVS_READ_I && !busy && AVS_ADDRESS_I == EVENT_STATUS_ADDR)
    |=> (AVS_READDATA_O == {26'h000_0000, $past(ev_status)});
  endproperty
  a_read_status: assert property (p_read_status) else $error("status readback wrong");

  property p_read_clear;
    @(posedge MCLK_I) disable iff (RESET_I)
    (AVS_READ_I && !busy && AVS_ADDRESS_I == EVENT_CLEAR_ADDR)
    |=> (AVS_READDATA_O == UNMAPPED_READ);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("clear register readable");

  property p_rdata_hold;
    @(posedge MCLK_I) disable iff (RESET_I)
    !(AVS_READ_I && !busy) |=> $stable(AVS_READDATA_O);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

  property p_status_set;
    @(posedge MCLK_I) disable iff (RESET_I)
    (ev_rise != 6'h00) |=> ((ev_status & $past(ev_rise)) == $past(ev_rise));
  endproperty
  a_status_set: assert property (p_status_set) else $error("event not latched");

  property p_status_sticky;
    @(posedge MCLK_I) disable iff (RESET_I)
    (ev_status[0] && !clr_mask[0]) |=> ev_status[0];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit lost");

  property p_status_clear;
    @(posedge MCLK_I) disable iff (RESET_I)
    (clr_mask[0] && !ev_rise[0]) |=> !ev_status[0];
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status bit not cleared");

  property p_irq_low;
    @(posedge MCLK_I) disable iff (RESET_I)
    ((ev_status & ev_enable) == 6'h00 && (ev_rise & ev_enable) == 6'h00) |=> !IRQ_O;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt without enabled event");

  property p_out_mirror;
    @(posedge MCLK_I) disable iff (RESET_I)
    1'b1 |=> (OVERCURRENT_SENSE_O == $past(cfg.indication));
  endproperty
  a_out_mirror: assert property (p_out_mirror) else $error("output not following route");

  property p_out_disabled;
    @(posedge MCLK_I) disable iff (RESET_I)
    (source[3][3:0] == SRC_DISABLED)[*3] |-> !OVERCURRENT_SENSE_O[3];
  endproperty
  a_out_disabled: assert property (p_out_disabled) else $error("disabled port output set");
endmodule

// ===== core/ocsel_pkg.sv
package ocsel_pkg;
  // ==========================================
  // register map (byte addresses)
  localparam int NUM_PORTS = 6;
  localparam logic [15:0] PORT1_OVERCURRENT_SOURCE_ADDR = 16'h3c20;
  localparam logic [15:0] PORT2_OVERCURRENT_SOURCE_ADDR = 16'h3c24;
  localparam logic [15:0] PORT3_OVERCURRENT_SOURCE_ADDR = 16'h3c28;
  localparam logic [15:0] PORT4_OVERCURRENT_SOURCE_ADDR = 16'h3c2c;
  localparam logic [15:0] PORT5_OVERCURRENT_SOURCE_ADDR = 16'h3c30;
  localparam logic [15:0] PORT6_OVERCURRENT_SOURCE_ADDR = 16'h3c34;
  localparam logic [15:0] SOURCE_STRIDE = 16'h0004;
  localparam logic [15:0] EVENT_STATUS_ADDR = 16'h3c40;
  localparam logic [15:0] EVENT_CLEAR_ADDR = 16'h3c44;
  localparam logic [15:0] EVENT_ENABLE_ADDR = 16'h3c48;
  localparam logic [15:0] INDICATION_ADDR = 16'h3c4c;
  // ==========================================
  // field layout and reset values
  localparam int FIELD_LSB = 0;
  localparam int FIELD_W = 4;
  localparam logic [7:0] SOURCE_RESET = 8'h00;
  localparam logic [5:0] EVENT_RESET = 6'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // ==========================================
  // source codes
  localparam logic [3:0] SRC_DISABLED = 4'h0;
  localparam logic [3:0] SRC_PIN = 4'h1;
  localparam logic [3:0] SRC_GPIO = 4'h2;
  localparam logic [3:0] SRC_FORCE = 4'hf;
endpackage

// ===== core/ocsel_cfg_if.sv
`timescale 1ns/1ps
interface ocsel_cfg_if;
  logic [7:0] source [6];
  logic [5:0] pin_sync;
  logic [5:0] gpio_sync;
  logic [5:0] indication;
  modport regs (output source, input indication);
  modport route (input source, input pin_sync, input gpio_sync, output indication);
  modport sync (output pin_sync, output gpio_sync);
endinterface

// ===== core/ocsel_sync.sv
`timescale 1ns/1ps
module ocsel_sync
  import ocsel_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  input wire logic [5:0] pin_i, // raw dedicated pins
  input wire logic [5:0] gpio_i, // raw general-purpose pins
  ocsel_cfg_if.sync cfg // filtered levels
);
  logic [5:0] p1, p2, p3, g1, g2, g3;
  logic [5:0] pin_q, gpio_q;

  // ==========================================
  // three stages, a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1 <= 6'h00;
      p2 <= 6'h00;
      p3 <= 6'h00;
      g1 <= 6'h00;
      g2 <= 6'h00;
      g3 <= 6'h00;
    end else begin
      p1 <= pin_i;
      p2 <= p1;
      p3 <= p2;
      g1 <= gpio_i;
      g2 <= g1;
      g3 <= g2;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= 6'h00;
      gpio_q <= 6'h00;
    end else begin
      pin_q <= (p2 & p3) | (pin_q & (p2 | p3));
      gpio_q <= (g2 & g3) | (gpio_q & (g2 | g3));
    end
  end

  assign cfg.pin_sync = pin_q;
  assign cfg.gpio_sync = gpio_q;
endmodule

// ===== core/ocsel_route.sv
`timescale 1ns/1ps
module ocsel_route
  import ocsel_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset
  ocsel_cfg_if.route cfg // selects in, indications out
);
  logic [5:0] ind;

  function automatic logic pick(input logic [3:0] sel, input logic pin, input logic gpio);
    logic r;
    r = 1'b0;
    case (sel)
      SRC_PIN: r = pin;
      SRC_GPIO: r = gpio;
      SRC_FORCE: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ==========================================
  // per port source selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ind <= 6'h00;
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        ind[i] <= pick(cfg.source[i][FIELD_LSB +: FIELD_W], cfg.pin_sync[i], cfg.gpio_sync[i]);
      end
    end
  end

  assign cfg.indication = ind;

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_chk
    property p_force;
      @(posedge clk_i) disable iff (rst_i)
      (cfg.source[g][3:0] == SRC_FORCE) |=> ind[g];
    endproperty
    a_force: assert property (p_force) else $error("forced port not asserted");
    property p_disabled;
      @(posedge clk_i) disable iff (rst_i)
      (cfg.source[g][3:0] == SRC_DISABLED) |=> !ind[g];
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled port indicates");
    property p_pin;
      @(posedge clk_i) disable iff (rst_i)
      (cfg.source[g][3:0] == SRC_PIN) |=> (ind[g] == $past(cfg.pin_sync[g]));
    endproperty
    a_pin: assert property (p_pin) else $error("pin source not followed");
    property p_gpio;
      @(posedge clk_i) disable iff (rst_i)
      (cfg.source[g][3:0] == SRC_GPIO) |=> (ind[g] == $past(cfg.gpio_sync[g]));
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio source not followed");
  end
endmodule

// ===== tb/oc_flag_model.sv
`timescale 1ns/1ps
// ==========================================
// external power switches: flag high while a switch has tripped
module oc_flag_model (
  input wire logic [5:0] pin_trip_i, // switches wired to sense pins
  input wire logic [5:0] gpio_trip_i, // switches wired to gpio pins
  output logic [5:0] pin_o, // dedicated flag lines
  output logic [5:0] gpio_o // gpio flag lines
);
  assign pin_o = pin_trip_i;
  assign gpio_o = gpio_trip_i;
endmodule

// ===== tb/overcurrent_source_select_tb.sv
`timescale 1ns/1ps
module overcurrent_source_select_tb;
  import ocsel_pkg::*;
  logic clk, rst, rd_req, wr_req, waitreq, irq;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] be;
  logic [5:0] pin_trip, gpio_trip, pin_w, gpio_w, sense, e;
  logic [3:0] codes [4] = '{SRC_DISABLED, SRC_PIN, SRC_GPIO, SRC_FORCE};
  int num_errors, checks, p, c, k;
  overcurrent_source_select overcurrent_source_select_inst (.MCLK_I(clk), .RESET_I(rst),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_req), .AVS_WRITE_I(wr_req),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .OVERCURRENT_SENSE_PIN_I(pin_w),
    .OVERCURRENT_SENSE_GPIO_I(gpio_w), .OVERCURRENT_SENSE_O(sense), .IRQ_O(irq));
  oc_flag_model oc_flag_model_inst (.pin_trip_i(pin_trip), .gpio_trip_i(gpio_trip),
    .pin_o(pin_w), .gpio_o(gpio_w));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one bus cycle: hold until waitrequest is sampled low
  task automatic acc(input logic we, input logic [15:0] a, input logic [31:0] d,
    input logic [3:0] b);
    int n;
    addr <= a;
    wr_req <= we;
    rd_req <= !we;
    wdata <= d;
    be <= b;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (waitreq === 1'b0) break;
    end
    rd = rdata;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    @(posedge clk);
    if (n == 40) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask
  task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0000_0000, 4'hf);
    chk(what, exp, rd);
  endtask
  // sense path has a few cycles of latency
  task automatic settle(input logic [5:0] es, input logic ei);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (sense === es && irq === ei) break;
    end
    chk("sense", {26'h0, es}, {26'h0, sense});
    chk("irq", {31'h0, ei}, {31'h0, irq});
  endtask
  function automatic logic [15:0] sa(input int i);
    return PORT1_OVERCURRENT_SOURCE_ADDR + 16'(i) * SOURCE_STRIDE;
  endfunction
  initial begin
    num_errors = 0;
    checks = 0;
    rst = 1'b1;
    rd_req = 1'b0;
    wr_req = 1'b0;
    addr = 16'h0000;
    wdata = 32'h0000_0000;
    be = 4'h0;
    pin_trip = 6'h00;
    gpio_trip = 6'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("waitreq", 32'h1, {31'h0, waitreq});
    for (p = 0; p < 6; p++) rchk("source", sa(p), 32'h0);
    $display("test reset done");
    // mixed codes per port, two pin patterns, junk in the upper nibble
    for (k = 0; k < 2; k++) begin
      pin_trip <= k ? 6'h2a : 6'h15;
      gpio_trip <= k ? 6'h15 : 6'h2a;
      for (c = 0; c < 4; c++) begin
        for (p = 0; p < 6; p++) wr(sa(p), {24'h0, 4'(p + 9), codes[(p + c) % 4]});
        for (p = 0; p < 6; p++) rchk("source", sa(p), {24'h0, 4'(p + 9), codes[(p + c) % 4]});
        for (p = 0; p < 6; p++) begin
          case ((p + c) % 4)
            0: e[p] = 1'b0;
            1: e[p] = pin_trip[p];
            2: e[p] = gpio_trip[p];
            default: e[p] = 1'b1;
          endcase
        end
        settle(e, 1'b0);
        rchk("indication", INDICATION_ADDR, {26'h0, e});
      end
    end
    $display("test codes done");
    acc(1'b1, sa(0), 32'h0000_0001, 4'he);
    rchk("lane", sa(0), 32'h0000_009f);
    rchk("unmapped", 16'h3c50, 32'h0);
    rchk("clear reads", EVENT_CLEAR_ADDR, 32'h0);
    $display("test refusals done");
    for (p = 0; p < 6; p++) wr(sa(p), {24'h0, SRC_DISABLED});
    settle(6'h00, 1'b0);
    wr(EVENT_CLEAR_ADDR, 32'h3f);
    wr(EVENT_ENABLE_ADDR, 32'h3f);
    for (p = 0; p < 6; p++) wr(sa(p), {24'h0, SRC_FORCE});
    settle(6'h3f, 1'b1);
    rchk("status", EVENT_STATUS_ADDR, 32'h3f);
    wr(EVENT_ENABLE_ADDR, 32'h00);
    settle(6'h3f, 1'b0);
    wr(EVENT_ENABLE_ADDR, 32'h3f);
    settle(6'h3f, 1'b1);
    wr(EVENT_CLEAR_ADDR, 32'h3f);
    settle(6'h3f, 1'b0);
    rchk("status", EVENT_STATUS_ADDR, 32'h0);
    $display("test interrupt done");
    stop_test();
  end
endmodule
